// ---- design/phy_mgmt_pkg.sv ----
// Constants and types for the PHY management access controller
package phy_mgmt_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL_LO = 12'h510;
  localparam logic [11:0] OFS_CTRL_HI = 12'h511;
  localparam logic [11:0] OFS_PHY_SEL = 12'h512;
  localparam logic [11:0] OFS_REG_SEL = 12'h513;
  localparam logic [11:0] OFS_DATA_LO = 12'h514;
  localparam logic [11:0] OFS_DATA_HI = 12'h515;
  localparam logic [11:0] OFS_M_CLAIM = 12'h516;
  localparam logic [11:0] OFS_L_CLAIM = 12'h517;
  localparam logic [11:0] OFS_STAT_B0 = 12'h518;
  localparam logic [11:0] OFS_STAT_B1 = 12'h519;
  localparam logic [11:0] OFS_STAT_B2 = 12'h51A;
  localparam logic [11:0] OFS_STAT_B3 = 12'h51B;
  // ----------------------------------------------------------------
  // Field positions (low byte, then high byte of control/status, then claim register bits)
  // ----------------------------------------------------------------
  localparam int WE_BIT = 0;
  localparam int LPOSS_BIT = 1;
  localparam int LINKDET_BIT = 2;
  localparam int P0ADDR_LSB = 3;
  localparam int CMD_LSB = 0;
  localparam int RDERR_BIT = 5;
  localparam int CMDERR_BIT = 6;
  localparam int BUSY_BIT = 7;
  localparam int OWN_BIT = 0;
  localparam int FORCE_BIT = 1;
  localparam int SEL_ADDR_W = 5;
  // ----------------------------------------------------------------
  // Commands and engine states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CMD_IDLE = 2'h0,
    CMD_READ = 2'h1,
    CMD_WRITE = 2'h2,
    CMD_BAD = 2'h3
  } cmd_t;
  typedef enum logic {
    ST_IDLE = 1'h0,
    ST_SHIFT = 1'h1
  } state_t;
  // ----------------------------------------------------------------
  // Management frame layout
  // ----------------------------------------------------------------
  localparam logic [31:0] FRM_PREAMBLE = 32'hFFFF_FFFF;
  localparam logic [1:0] FRM_START = 2'h1;
  localparam logic [1:0] FRM_OP_RD = 2'h2;
  localparam logic [1:0] FRM_OP_WR = 2'h1;
  localparam logic [1:0] FRM_TA_WR = 2'h2;
  localparam logic [1:0] FRM_TA_RD = 2'h3;
  localparam logic [15:0] FRM_IDLE_DATA = 16'hFFFF;
  localparam logic [5:0] FRM_LAST = 6'h3F;
  localparam logic [5:0] FRM_TURN = 6'h2E;
  localparam logic [5:0] FRM_TA_CHK = 6'h2F;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int MCLK_PERIOD_NS = 100;
  localparam int MDC_PERIOD_NS = 800;
  localparam int MDC_CYC =
    (MDC_PERIOD_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int MDC_HALF = MDC_CYC / 2;
endpackage

// ---- design/phy_mgmt_access_control.sv ----
// PHY management access controller with two requester ports
// ------------------------------------------------------------------
// Functional notes
// (R1) Write-enable bit 0 gates writes; reads 1 when local port owns.
// (R2) Write enable self-clears at next frame start or local access end.
// (R3) Bit 1 reports whether local port takeover is possible.
// (R4) Bit 2 reports whether automatic link detection is active.
// (R5) Bits 7:3 show port 0 Phy_select, never writable.
// (R6) Command codes: 00 idle, 01 read, 10 write; 11 invalid.
// (R7) Writing the command starts it; reading shows running command.
// (R8) Command field returns to zero when busy drops.
// (R9) Writing command 00 clears both error flags.
// (R10) Bit 13 flags failed read; any control write clears it.
// (R11) Bit 14 flags invalid command or write without write enable.
// (R12) Bit 15 is busy while the engine runs an operation.
// (R13) Writable management fields ignore writes while busy.
// (R14) Only the current owner may write the writable fields.
// (R15) Requester loads the PHY register number before a command.
// (R16) Local ownership bit selects master side or local port.
// (R17) Master claim writable only while local ownership is 0.
// (R18) Master force write returns ownership to the master side.
// (R19) Read fills data register from PHY; write sends data register.
// (R20) Requester polls busy, then errors, before next command.
// ------------------------------------------------------------------
`timescale 1ns/10ps
module phy_mgmt_access_control (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [11:0] masterAddr,
  input wire logic masterWr,
  input wire logic [7:0] masterWdata,
  output logic [7:0] masterRdata,
  input wire logic [11:0] localAddr,
  input wire logic localWr,
  input wire logic [7:0] localWdata,
  output logic [7:0] localRdata,
  input wire logic frameStart,
  input wire logic localAccessEnd,
  input wire logic localCtrlPossible,
  input wire logic linkDetectActive,
  input wire logic [4:0] port0PhyAddr,
  input wire logic [31:0] phyPortStatus,
  output logic mdc,
  input wire logic mdioIn,
  output logic mdioOut,
  output logic mdioOe_n
);
  import phy_mgmt_pkg::*;
  localparam int DIV_W = $clog2(MDC_CYC);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MDC_CYC - 1);
  localparam logic [DIV_W-1:0] DIV_HALF = DIV_W'(MDC_HALF);
  localparam logic [DIV_W-1:0] DIV_ZERO = '0;
  state_t state_r;
  cmd_t cmd_r;
  logic we_r;
  logic rdErr_r;
  logic cmdErr_r;
  logic localOwn_r;
  logic masterClaim_r;
  logic [7:0] phySel_r;
  logic [7:0] regSel_r;
  logic [15:0] data_r;
  logic [63:0] frame_r;
  logic [15:0] rdShift_r;
  logic readFail_r;
  logic [5:0] bitCnt_r;
  logic [DIV_W-1:0] divCnt_r;
  logic mdioMeta_r;
  logic mdioSync_r;
  logic mdc_r;
  logic mdioOut_r;
  logic mdioOe_n_r;
  logic [7:0] masterRdata_r;
  logic [7:0] localRdata_r;
  // ----------------------------------------------------------------
  // Ownership and write qualification
  // ----------------------------------------------------------------
  logic busy;
  logic weEff;
  logic ownWr;
  logic [11:0] ownAddr;
  logic [7:0] ownData;
  logic mgmtWr;
  logic ctrlWr;
  logic cmdWr;
  cmd_t cmdCode;
  logic startOp;
  logic done;
  assign busy = (state_r == ST_SHIFT); // R12
  assign weEff = we_r | localOwn_r; // R1
  assign ownWr = localOwn_r ? localWr : masterWr; // R14 R16
  assign ownAddr = localOwn_r ? localAddr : masterAddr;
  assign ownData = localOwn_r ? localWdata : masterWdata;
  assign mgmtWr = ownWr & ~busy; // R13
  assign ctrlWr = mgmtWr &
    ((ownAddr == OFS_CTRL_LO) | (ownAddr == OFS_CTRL_HI));
  assign cmdWr = mgmtWr & (ownAddr == OFS_CTRL_HI);
  assign cmdCode = cmd_t'(ownData[CMD_LSB +: 2]);
  assign startOp = cmdWr & ((cmdCode == CMD_READ) |
    ((cmdCode == CMD_WRITE) & weEff)); // R6 R7 R1
  assign done = busy & (divCnt_r == DIV_LAST) &
    (bitCnt_r == FRM_LAST);
  // ----------------------------------------------------------------
  // Write enable
  // ----------------------------------------------------------------
  // Only the master side may set it; a local-port write has no effect.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      we_r <= 1'b0;
    end else if (masterWr & ~localOwn_r & ~busy &
                 (masterAddr == OFS_CTRL_LO)) begin
      we_r <= masterWdata[WE_BIT]; // R1
    end else if (frameStart | localAccessEnd) begin
      we_r <= 1'b0; // R2
    end
  end
  // ----------------------------------------------------------------
  // Command, busy and engine state
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      cmd_r <= CMD_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (startOp) begin
            state_r <= ST_SHIFT; // R7
            cmd_r <= cmdCode;
          end
        end
        ST_SHIFT: begin
          if (done) begin
            state_r <= ST_IDLE;
            cmd_r <= CMD_IDLE; // R8
          end
        end
      endcase
    end
  end
  // ----------------------------------------------------------------
  // Error flags
  // ----------------------------------------------------------------
  // Writes are blocked while busy, so a fail set never meets a clear.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdErr_r <= 1'b0;
    end else if (done & (cmd_r == CMD_READ) & readFail_r) begin
      rdErr_r <= 1'b1; // R10
    end else if (ctrlWr) begin
      rdErr_r <= 1'b0; // R10 R9
    end
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cmdErr_r <= 1'b0;
    end else if (cmdWr) begin
      cmdErr_r <= (cmdCode == CMD_BAD) |
        ((cmdCode == CMD_WRITE) & ~weEff); // R11 R9 R6
    end
  end
  // ----------------------------------------------------------------
  // Ownership registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      masterClaim_r <= 1'b0;
    end else if (masterWr & ~localOwn_r &
                 (masterAddr == OFS_M_CLAIM)) begin
      masterClaim_r <= masterWdata[OWN_BIT]; // R17
    end
  end
  // Force from the master side wins over a local takeover.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      localOwn_r <= 1'b0;
    end else if (masterWr & (masterAddr == OFS_L_CLAIM) &
                 masterWdata[FORCE_BIT]) begin
      localOwn_r <= 1'b0; // R18
    end else if (localWr & (localAddr == OFS_L_CLAIM) &
                 ~masterClaim_r & localCtrlPossible) begin
      localOwn_r <= localWdata[OWN_BIT]; // R16
    end
  end
  // ----------------------------------------------------------------
  // Address and data registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      phySel_r <= 8'h00;
    end else if (mgmtWr & (ownAddr == OFS_PHY_SEL)) begin
      phySel_r <= ownData; // R14
    end
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      regSel_r <= 8'h00;
    end else if (mgmtWr & (ownAddr == OFS_REG_SEL)) begin
      regSel_r <= ownData; // R15
    end
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      data_r <= 16'h0000;
    end else if (done & (cmd_r == CMD_READ)) begin
      data_r <= rdShift_r; // R19
    end else if (mgmtWr & (ownAddr == OFS_DATA_LO)) begin
      data_r[7:0] <= ownData;
    end else if (mgmtWr & (ownAddr == OFS_DATA_HI)) begin
      data_r[15:8] <= ownData;
    end
  end
  // ----------------------------------------------------------------
  // Management bus engine
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      mdioMeta_r <= 1'b1;
      mdioSync_r <= 1'b1;
    end else begin
      mdioMeta_r <= mdioIn;
      mdioSync_r <= mdioMeta_r;
    end
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      divCnt_r <= DIV_ZERO;
      bitCnt_r <= 6'h00;
    end else if (~busy) begin
      divCnt_r <= DIV_ZERO;
      bitCnt_r <= 6'h00;
    end else if (divCnt_r == DIV_LAST) begin
      divCnt_r <= DIV_ZERO;
      bitCnt_r <= bitCnt_r + 6'h01;
    end else begin
      divCnt_r <= divCnt_r + DIV_W'(1);
    end
  end
  // Frame is latched at start so register writes cannot disturb it.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      frame_r <= '1;
    end else if (startOp) begin
      frame_r <= {FRM_PREAMBLE, FRM_START,
        (cmdCode == CMD_READ) ? FRM_OP_RD : FRM_OP_WR,
        phySel_r[SEL_ADDR_W-1:0], regSel_r[SEL_ADDR_W-1:0],
        (cmdCode == CMD_READ) ? FRM_TA_RD : FRM_TA_WR,
        (cmdCode == CMD_READ) ? FRM_IDLE_DATA : data_r}; // R19
    end else if (busy & (divCnt_r == DIV_ZERO)) begin
      frame_r <= {frame_r[62:0], 1'b1};
    end
  end
  // MDIO is sampled on the rising half; TA bit must be pulled low.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdShift_r <= 16'h0000;
      readFail_r <= 1'b0;
    end else if (startOp) begin
      readFail_r <= 1'b0;
    end else if (busy & (divCnt_r == DIV_HALF)) begin
      rdShift_r <= {rdShift_r[14:0], mdioSync_r};
      if ((bitCnt_r == FRM_TA_CHK) & mdioSync_r) begin
        readFail_r <= 1'b1; // R10
      end
    end
  end
  // Clock ends its last high half in full before the pins go idle.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      mdc_r <= 1'b0;
      mdioOut_r <= 1'b1;
      mdioOe_n_r <= 1'b1;
    end else if (~busy) begin
      mdc_r <= 1'b0;
      mdioOut_r <= 1'b1;
      mdioOe_n_r <= 1'b1;
    end else begin
      if (divCnt_r == DIV_HALF) begin
        mdc_r <= 1'b1;
      end else if (divCnt_r == DIV_ZERO) begin
        mdc_r <= 1'b0;
        mdioOut_r <= frame_r[63];
        mdioOe_n_r <= ~((cmd_r == CMD_WRITE) |
          (bitCnt_r < FRM_TURN));
      end
    end
  end
  // ----------------------------------------------------------------
  // Read-back
  // ----------------------------------------------------------------
  function automatic logic [7:0] regByte(input logic [11:0] a);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      OFS_CTRL_LO: begin
        v[WE_BIT] = weEff; // R1
        v[LPOSS_BIT] = localCtrlPossible; // R3
        v[LINKDET_BIT] = linkDetectActive; // R4
        v[P0ADDR_LSB +: 5] = port0PhyAddr; // R5
      end
      OFS_CTRL_HI: begin
        v[CMD_LSB +: 2] = cmd_r; // R7
        v[RDERR_BIT] = rdErr_r;
        v[CMDERR_BIT] = cmdErr_r;
        v[BUSY_BIT] = busy; // R12
      end
      OFS_PHY_SEL: v = phySel_r;
      OFS_REG_SEL: v = regSel_r;
      OFS_DATA_LO: v = data_r[7:0];
      OFS_DATA_HI: v = data_r[15:8];
      OFS_M_CLAIM: v[OWN_BIT] = masterClaim_r;
      OFS_L_CLAIM: v[OWN_BIT] = localOwn_r;
      OFS_STAT_B0: v = phyPortStatus[7:0];
      OFS_STAT_B1: v = phyPortStatus[15:8];
      OFS_STAT_B2: v = phyPortStatus[23:16];
      OFS_STAT_B3: v = phyPortStatus[31:24];
      default: v = 8'h00;
    endcase
    return v;
  endfunction
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      masterRdata_r <= 8'h00;
      localRdata_r <= 8'h00;
    end else begin
      masterRdata_r <= regByte(masterAddr);
      localRdata_r <= regByte(localAddr);
    end
  end

  assign masterRdata = masterRdata_r;
  assign localRdata = localRdata_r;
  assign mdc = mdc_r;
  assign mdioOut = mdioOut_r;
  assign mdioOe_n = mdioOe_n_r;
endmodule

// ---- bench/phy_mgmt_assertions.sv ----
// Port-level checker for the PHY management controller
`timescale 1ns/10ps
module phy_mgmt_assertions
  import phy_mgmt_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [11:0] masterAddr,
  input wire logic masterWr,
  input wire logic [7:0] masterWdata,
  input wire logic [7:0] masterRdata,
  input wire logic [11:0] localAddr,
  input wire logic localWr,
  input wire logic [7:0] localRdata,
  input wire logic localCtrlPossible,
  input wire logic linkDetectActive,
  input wire logic [4:0] port0PhyAddr,
  input wire logic mdc,
  input wire logic mdioOut,
  input wire logic mdioOe_n
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  // ----
  // Register views
  // ----
  a_port0_addr: assert property (masterAddr == OFS_CTRL_LO |=>
    masterRdata[7:3] == $past(port0PhyAddr)) else $error("port0 addr");
  a_strap_bits: assert property (localAddr == OFS_CTRL_LO |=>
    localRdata[2:1] == {$past(linkDetectActive), $past(localCtrlPossible)})
    else $error("strap bits");
  a_we_local: assert property (!masterWr && !localWr &&
    masterAddr == OFS_L_CLAIM ##1 !masterWr && !localWr &&
    masterAddr == OFS_CTRL_LO && masterRdata[OWN_BIT] |=> masterRdata[0])
    else $error("write enable");
  a_force_back: assert property (masterWr &&
    masterAddr == OFS_L_CLAIM && masterWdata[FORCE_BIT] ##1
    masterAddr == OFS_L_CLAIM && !localWr |=> !masterRdata[OWN_BIT])
    else $error("force");
  a_busy_cmd: assert property (masterAddr == OFS_CTRL_HI |=>
    !masterRdata[BUSY_BIT] || masterRdata[1:0] inside {2'h1, 2'h2})
    else $error("busy cmd");
  a_cmd_clear: assert property ($past(masterAddr) == OFS_CTRL_HI &&
    $past(masterAddr, 2) == OFS_CTRL_HI && $fell(masterRdata[BUSY_BIT])
    |-> masterRdata[1:0] == 2'h0) else $error("cmd clear");
  // ----
  // Management wire
  // ----
  a_mdio_stable: assert property (mdc && !mdioOe_n |->
    $stable(mdioOut)) else $error("mdio moved");
  a_mdc_high: assert property ($rose(mdc) |->
    mdc[*4] ##1 !mdc) else $error("mdc high");
  c_turn: cover property ($rose(mdioOe_n));
  c_busy: cover property ($fell(masterRdata[BUSY_BIT]));
  c_force: cover property (masterWr && masterWdata[FORCE_BIT]);
endmodule
bind phy_mgmt_access_control phy_mgmt_assertions u_chk (
  .mclk(mclk), .sys_rst(sys_rst), .masterAddr(masterAddr),
  .masterWr(masterWr), .masterWdata(masterWdata),
  .masterRdata(masterRdata), .localAddr(localAddr),
  .localWr(localWr), .localRdata(localRdata),
  .localCtrlPossible(localCtrlPossible),
  .linkDetectActive(linkDetectActive), .port0PhyAddr(port0PhyAddr),
  .mdc(mdc), .mdioOut(mdioOut), .mdioOe_n(mdioOe_n));

// ---- bench/phy_model.sv ----
// Behavioural PHY answering on the management bus
`timescale 1ns/10ps
module phy_model
  import phy_mgmt_pkg::*;
#(
  parameter logic [4:0] PHY_ADDR = 5'h05
) (
  input wire logic mdc,
  input wire logic mdio,
  output logic phyOe,
  output logic phyOut
);
  logic [15:0] mem [32];
  logic [15:0] sh = 16'h0000;
  logic [4:0] rg = 5'h00;
  logic [1:0] op = 2'h0;
  logic hit = 1'b0;
  logic on = 1'b0;
  logic oe = 1'b0;
  logic dq = 1'b1;
  int n = 0;
  assign phyOe = oe;
  assign phyOut = dq;
  initial begin
    foreach (mem[i]) begin
      mem[i] = 16'h0000;
    end
  end
  // ----
  // Frame decode on the rising clock
  // ----
  always @(posedge mdc) begin
    sh <= {sh[14:0], mdio};
    n <= n + 1;
    if (!on && sh[8:0] == 9'h1FE && mdio) begin
      on <= 1'b1;
      n <= 0;
    end
    if (on && n == 11) begin
      op <= sh[10:9];
      hit <= sh[8:4] == PHY_ADDR;
      rg <= {sh[3:0], mdio};
    end
    if (on && n == 29) begin
      on <= 1'b0;
      // Cleared so stale data cannot fake a start
      sh <= 16'h0000;
      if (hit && op == FRM_OP_WR) begin
        mem[rg] <= {sh[14:0], mdio};
      end
    end
  end
  // Unaddressed PHY stays off; pull-up then shows a missing answer
  always @(negedge mdc) begin
    oe <= on && hit && op == FRM_OP_RD && n >= 13;
    dq <= n == 13 ? 1'b0 : mem[rg][5'(29 - n)];
  end
endmodule

// ---- bench/tb.sv ----
// Self-checking testbench for the PHY management controller
`timescale 1ns/10ps
module tb;
  import phy_mgmt_pkg::*;
  typedef struct {logic s; logic [7:0] e; logic [7:0] m;} note_t;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [11:0] addr = 12'h000;
  logic [7:0] wd = 8'h00;
  logic mWr = 1'b0;
  logic lWr = 1'b0;
  logic fs = 1'b0;
  logic lae = 1'b0;
  logic lposs = 1'b0;
  logic link = 1'b0;
  logic [4:0] p0 = 5'h00;
  logic [31:0] pst = 32'h0;
  logic rdReq = 1'b0;
  logic pend = 1'b0;
  logic [7:0] mRd, lRd, got;
  logic mdc, mdioOut, mdioOe_n, phyOe, phyOut;
  wire mdio = !mdioOe_n ? mdioOut : phyOe ? phyOut : 1'b1;
  note_t q[$];
  note_t nt;
  int fails = 0;
  int n_checks = 0;
  phy_mgmt_access_control u_dut (.mclk(mclk), .sys_rst(sys_rst),
    .masterAddr(addr), .masterWr(mWr), .masterWdata(wd),
    .masterRdata(mRd), .localAddr(addr), .localWr(lWr),
    .localWdata(wd), .localRdata(lRd), .frameStart(fs),
    .localAccessEnd(lae), .localCtrlPossible(lposs),
    .linkDetectActive(link), .port0PhyAddr(p0), .phyPortStatus(pst),
    .mdc(mdc), .mdioIn(mdio), .mdioOut(mdioOut), .mdioOe_n(mdioOe_n));
  phy_model u_phy (.mdc(mdc), .mdio(mdio), .phyOe(phyOe),
    .phyOut(phyOut));
  initial begin
    forever #50 mclk = ~mclk;
  end
  task automatic close_out();
    if (fails == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ----
  // One bus cycle per call, except poll, which repeats control reads until busy drops
  // ----
  task automatic op(logic s, logic w, logic [11:0] a, logic [7:0] d,
      logic c, logic [7:0] e, logic [7:0] m, logic [1:0] ev = 2'b00);
    @(posedge mclk);
    addr <= a;
    wd <= d;
    mWr <= w && !s;
    lWr <= w && s;
    rdReq <= c;
    fs <= ev[0];
    lae <= ev[1];
    if (c) q.push_back('{s, e, m});
  endtask
  task automatic wr(logic s, logic [11:0] a, logic [7:0] d);
    op(s, 1'b1, a, d, 1'b0, 8'h00, 8'h00);
  endtask
  task automatic rd(logic s, logic [11:0] a, logic [7:0] e, logic [7:0] m);
    op(s, 1'b0, a, 8'h00, 1'b1, e, m);
  endtask
  task automatic poll();
    for (int i = 0; i < 700; i++) begin
      op(1'b0, 1'b0, OFS_CTRL_HI, 8'h00, 1'b0, 8'h00, 8'h00);
      @(negedge mclk);
      if (i > 0 && mRd[BUSY_BIT] === 1'b0) return;
    end
    fails++;
    $display("unexpected at %0t: busy stuck", $time);
    close_out();
  endtask
  always @(posedge mclk) pend <= rdReq;
  always @(negedge mclk) begin
    if (pend && q.size() > 0) begin
      nt = q.pop_front();
      got = nt.s ? lRd : mRd;
      n_checks++;
      if ((got & nt.m) !== (nt.e & nt.m)) begin
        fails++;
        $display("unexpected at %0t: got %h want %h", $time, got, nt.e);
      end
    end
  end
  initial begin
    logic [15:0] d;
    logic [4:0] r;
    void'($urandom(32'h6F00));
    @(posedge mclk);
    p0 <= 5'($urandom);
    link <= 1'($urandom);
    lposs <= 1'($urandom);
    pst <= $urandom;
    d = 16'($urandom);
    r = 5'($urandom);
    repeat (7) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(0, OFS_CTRL_LO, {p0, link, lposs, 1'b0}, 8'hFF);
    wr(0, OFS_CTRL_LO, {~p0, 3'h7});
    rd(1, OFS_CTRL_LO, {p0, link, lposs, 1'b1}, 8'hFF);
    for (int i = 0; i < 4; i++) begin
      rd(i[0], OFS_STAT_B0 + 12'(i), pst[8*i +: 8], 8'hFF);
    end
    rd(1, 12'h600, 8'h00, 8'hFF);
    op(0, 1'b0, OFS_CTRL_LO, 8'h00, 1'b0, 8'h00, 8'h00, 2'b01);
    rd(0, OFS_CTRL_LO, 8'h00, 8'h01);
    wr(0, OFS_CTRL_HI, 8'h02);
    rd(0, OFS_CTRL_HI, 8'h40, 8'hC3);
    wr(0, OFS_CTRL_HI, 8'h00);
    rd(0, OFS_CTRL_HI, 8'h00, 8'hC3);
    wr(0, OFS_CTRL_HI, 8'h03);
    rd(0, OFS_CTRL_HI, 8'h40, 8'hC0);
    wr(0, OFS_CTRL_LO, 8'h01);
    wr(0, OFS_PHY_SEL, 8'h05);
    wr(0, OFS_REG_SEL, {3'h0, r});
    wr(0, OFS_DATA_LO, d[7:0]);
    wr(0, OFS_DATA_HI, d[15:8]);
    wr(0, OFS_CTRL_HI, 8'h02);
    wr(0, OFS_DATA_LO, ~d[7:0]);
    rd(0, OFS_CTRL_HI, 8'h82, 8'hE3);
    poll();
    rd(0, OFS_CTRL_HI, 8'h00, 8'hE3);
    rd(0, OFS_DATA_LO, d[7:0], 8'hFF);
    wr(0, OFS_DATA_LO, 8'h00);
    wr(0, OFS_DATA_HI, 8'h00);
    wr(0, OFS_CTRL_HI, 8'h01);
    poll();
    rd(0, OFS_CTRL_HI, 8'h00, 8'hE3);
    rd(0, OFS_DATA_LO, d[7:0], 8'hFF);
    rd(0, OFS_DATA_HI, d[15:8], 8'hFF);
    wr(0, OFS_PHY_SEL, 8'h06);
    wr(0, OFS_CTRL_HI, 8'h01);
    poll();
    rd(0, OFS_CTRL_HI, 8'h20, 8'hE3);
    wr(0, OFS_CTRL_LO, 8'h01);
    rd(0, OFS_CTRL_HI, 8'h00, 8'h20);
    wr(0, OFS_CTRL_HI, 8'h01);
    poll();
    wr(0, OFS_CTRL_HI, 8'h00);
    rd(0, OFS_CTRL_HI, 8'h00, 8'hE3);
    lposs <= 1'b1;
    wr(1, OFS_L_CLAIM, 8'h01);
    rd(0, OFS_L_CLAIM, 8'h01, 8'h01);
    rd(1, OFS_CTRL_LO, {p0, link, 2'b11}, 8'hFF);
    wr(0, OFS_M_CLAIM, 8'h01);
    rd(0, OFS_M_CLAIM, 8'h00, 8'h01);
    wr(0, OFS_REG_SEL, {3'h0, ~r});
    wr(1, OFS_DATA_LO, ~d[7:0]);
    rd(1, OFS_REG_SEL, {3'h0, r}, 8'hFF);
    rd(1, OFS_DATA_LO, ~d[7:0], 8'hFF);
    op(1, 1'b0, OFS_CTRL_LO, 8'h00, 1'b0, 8'h00, 8'h00, 2'b10);
    rd(0, OFS_CTRL_LO, 8'h01, 8'h01);
    wr(0, OFS_L_CLAIM, 8'h02);
    rd(0, OFS_L_CLAIM, 8'h00, 8'h01);
    rd(0, OFS_CTRL_LO, 8'h00, 8'h01);
    wr(0, OFS_M_CLAIM, 8'h01);
    rd(0, OFS_M_CLAIM, 8'h01, 8'h01);
    wr(1, OFS_L_CLAIM, 8'h01);
    rd(1, OFS_L_CLAIM, 8'h00, 8'h01);
    repeat (3) @(posedge mclk);
    close_out();
  end
endmodule
